// File: core/ssf_map.svh
// register offsets, field positions, reset values of the serial status block
// assumes a 32-bit apb slave decoding byte addresses on 8 address bits
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH

`define SSF_ADDR_W 8
`define SSF_STATUS_OFF 8'h00
`define SSF_CTRL_OFF 8'h04

`define SSF_TX_EMPTY_BIT 7
`define SSF_RX_FULL_BIT 6
`define SSF_OVERRUN_BIT 5
`define SSF_FRAME_ERS_BIT 4
`define SSF_PARITY_BIT 3
`define SSF_TX_END_BIT 2
`define SSF_RX_MPB_BIT 1
`define SSF_TX_MPB_BIT 0
`define SSF_FLAG_LO 3
`define SSF_FLAG_HI 7

`define SSF_CTRL_TE_BIT 0
`define SSF_CTRL_RE_BIT 1
`define SSF_CTRL_CARD_BIT 2

`define SSF_STATUS_RST 8'h84
`define SSF_CTRL_RST 3'h0
`define SSF_PIN_IDLE 1'b1

`endif

// File: core/ssf_pkg.sv
// types shared by the serial status block
// assumes ssf_map.svh holds every number
package ssf_pkg;

    typedef struct packed {
        logic transmit_enable;
        logic receive_enable;
        logic card_mode_select;
    } ssf_ctrl_s;

    typedef struct packed {
        logic done;
        logic stop1;
        logic parity_err;
        logic rx_multiproc_bit;
    } ssf_rx_evt_s;

    typedef struct packed {
        logic load;
        logic last_bit;
        logic ctl_write;
    } ssf_tx_evt_s;

    typedef logic [7:0] ssf_byte_t;

endpackage : ssf_pkg

// File: core/ssf_sync.sv
// two-flop synchroniser for a pin level
// assumes the pin idles high
`timescale 1ns/1ps
`include "ssf_map.svh"
module ssf_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level_q
);
    logic meta_q;
    logic meta_d;
    logic level_d;

    always_comb begin
        meta_d = pin;
        level_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= `SSF_PIN_IDLE;
            level_q <= `SSF_PIN_IDLE;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end
endmodule : ssf_sync

// File: core/ssf_flag.sv
// one status flag cleared by reading 1 then writing 0
// assumes strobes are one-cycle pulses on pclk
`timescale 1ns/1ps
module ssf_flag #(
    parameter logic RST = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set,
    input wire logic hw_clr,
    input wire logic rd_stb,
    input wire logic rd_bit,
    input wire logic wr_stb,
    input wire logic wr_bit,
    output logic flag_q,
    output logic armed_q
);
    logic flag_d;
    logic armed_d;
    logic sw_clr;

    always_comb begin
        sw_clr = wr_stb && !wr_bit && armed_q; // see RULE2
        // set beats any clear; writing 1 does nothing
        flag_d = set || (flag_q && !(sw_clr || hw_clr)); // see RULE21 see RULE19
        armed_d = armed_q;
        if (rd_stb && rd_bit) begin
            armed_d = 1'b1;
        end else if (wr_stb) begin
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= RST;
            armed_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end
endmodule : ssf_flag

// File: core/ssf_status.sv
// serial status flags with an apb register port
// assumes shift engines and transfer controller run on pclk and give one-cycle pulses
//
// Behaviour
// RULE1 - overrun sets when a reception completes while receive-full is 1
// RULE2 - overrun clears only on a 0 write after reading it as 1
// RULE3 - normal mode: stop bit 0 sets framing error; read-1-write-0 clears it
// RULE4 - with two stop bits only the first stop bit is checked
// RULE5 - parity mismatch sets parity error; read-1-write-0 clears it
// RULE6 - transmit-end set while transmit disabled or last bit sent with empty 1
// RULE7 - transmit-end clears on transmit-empty software clear or controller write
// RULE8 - received multiprocessor bit is captured from each received character; the code captures it only while card mode select is 0
// RULE9 - received multiprocessor bit holds when receive enable is 0
// RULE10 - writable transfer bit supplies the transmitted multiprocessor bit
// RULE11 - transmit-empty set while transmit disabled or on holding-to-shifter move
// RULE12 - transmit-empty clears on read-1-write-0 or controller transmit write
// RULE13 - receive-full sets when an error-free byte moves into the holding register
// RULE14 - receive-full clears on read-1-write-0 or controller receive read
// RULE15 - clearing receive enable leaves receive-full unchanged
// RULE16 - card mode select 1 makes bit 4 the error signal flag
// RULE17 - card mode: sampled low error signal sets the error signal flag
// RULE18 - error signal flag clears only on read-1-write-0
// RULE19 - writing 1 to the clearable flags has no effect
// RULE20 - card mode select 0 gives normal framing and multiprocessor meanings
// RULE21 - a hardware set beats a software clear in the same cycle
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ssf_map.svh"
module ssf_status
    import ssf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SSF_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire ssf_rx_evt_s rx_evt,
    input wire ssf_tx_evt_s tx_evt,
    input wire logic ctl_rx_read,
    input wire logic card_err_sample,
    input wire logic card_err_pin,
    output ssf_byte_t serial_status,
    output ssf_ctrl_s serial_control,
    output logic tx_multiproc_bit,
    output logic transmit_request,
    output logic receive_request,
    output logic rx_accept
);
    function automatic logic addr_hit(input logic [`SSF_ADDR_W-1:0] a,
                                      input logic [`SSF_ADDR_W-1:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    // bus state
    logic pready_d;
    logic pready_q;
    logic pslverr_d;
    logic pslverr_q;
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;
    logic done_rd;
    logic done_wr;
    logic wr_status;
    logic wr_ctrl;
    logic rd_status;
    logic mapped;

    // control and status state
    ssf_ctrl_s ctrl_d;
    ssf_ctrl_s ctrl_q;
    logic tx_mpb_d;
    logic tx_mpb_q;
    logic rx_mpb_d;
    logic rx_mpb_q;
    logic transmit_end_flag_d;
    logic transmit_end_flag_q;
    logic treq_d;
    logic treq_q;
    logic rreq_d;
    logic rreq_q;
    logic acc_d;
    logic acc_q;
    logic transmit_empty_flag_sw_clr;
    logic err_level;
    logic rx_live;
    logic rx_clean;

    logic [`SSF_FLAG_HI:`SSF_FLAG_LO] fl_set;
    logic [`SSF_FLAG_HI:`SSF_FLAG_LO] fl_hwclr;
    logic [`SSF_FLAG_HI:`SSF_FLAG_LO] fl_q;
    logic [`SSF_FLAG_HI:`SSF_FLAG_LO] fl_armed;
    ssf_byte_t status_now;

    ssf_sync u_err_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(card_err_pin),
        .level_q(err_level)
    );

    // apb decode and answer, no wait states
    always_comb begin
        mapped = addr_hit(paddr, `SSF_STATUS_OFF) || addr_hit(paddr, `SSF_CTRL_OFF);
        done_rd = psel && penable && pready_q && !pwrite;
        done_wr = psel && penable && pready_q && pwrite && !pslverr_q;
        wr_status = done_wr && addr_hit(paddr, `SSF_STATUS_OFF);
        wr_ctrl = done_wr && addr_hit(paddr, `SSF_CTRL_OFF);
        rd_status = done_rd && addr_hit(paddr, `SSF_STATUS_OFF) && !pslverr_q;
        pready_d = psel && !penable;
        pslverr_d = psel && !penable && !mapped;
        prdata_d = prdata_q;
        if (psel && !penable) begin
            prdata_d = 32'h0;
            if (addr_hit(paddr, `SSF_STATUS_OFF)) begin
                prdata_d[7:0] = status_now;
            end else if (addr_hit(paddr, `SSF_CTRL_OFF)) begin
                prdata_d[`SSF_CTRL_TE_BIT] = ctrl_q.transmit_enable;
                prdata_d[`SSF_CTRL_RE_BIT] = ctrl_q.receive_enable;
                prdata_d[`SSF_CTRL_CARD_BIT] = ctrl_q.card_mode_select;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // flag set and hardware clear terms
    always_comb begin
        rx_live = rx_evt.done && ctrl_q.receive_enable;
        rx_clean = rx_live && !fl_q[`SSF_RX_FULL_BIT] && !rx_evt.parity_err
                   && (ctrl_q.card_mode_select || rx_evt.stop1);
        fl_set = '0;
        fl_hwclr = '0;
        fl_set[`SSF_TX_EMPTY_BIT] = !ctrl_q.transmit_enable || tx_evt.load; // see RULE11
        fl_hwclr[`SSF_TX_EMPTY_BIT] = tx_evt.ctl_write; // see RULE12
        // receive enable low blocks new sets but never clears
        fl_set[`SSF_RX_FULL_BIT] = rx_clean; // see RULE13 see RULE15
        fl_hwclr[`SSF_RX_FULL_BIT] = ctl_rx_read; // see RULE14
        fl_set[`SSF_OVERRUN_BIT] = rx_live && fl_q[`SSF_RX_FULL_BIT]; // see RULE1
        if (ctrl_q.card_mode_select) begin
            fl_set[`SSF_FRAME_ERS_BIT] = card_err_sample && !err_level; // see RULE16 see RULE17
        end else begin
            // only the first stop bit is examined
            fl_set[`SSF_FRAME_ERS_BIT] = rx_live && !rx_evt.stop1; // see RULE3 see RULE4 see RULE20
        end
        fl_set[`SSF_PARITY_BIT] = rx_live && rx_evt.parity_err; // see RULE5
    end

    // clearable flags, bit 4 shares its cell between modes
    generate
        for (genvar i = `SSF_FLAG_LO; i <= `SSF_FLAG_HI; i++) begin : g_flag
            ssf_flag #(
                .RST(1'(`SSF_STATUS_RST >> i))
            ) u_flag (
                .pclk(pclk),
                .presetn(presetn),
                .set(fl_set[i]),
                .hw_clr(fl_hwclr[i]),
                .rd_stb(rd_status),
                .rd_bit(prdata_q[i]),
                .wr_stb(wr_status),
                .wr_bit(pwdata[i]),
                .flag_q(fl_q[i]), // see RULE18
                .armed_q(fl_armed[i])
            );
        end
    endgenerate

    // transmit end, multiprocessor bits, control, request outputs
    always_comb begin
        transmit_empty_flag_sw_clr = wr_status && !pwdata[`SSF_TX_EMPTY_BIT] && fl_armed[`SSF_TX_EMPTY_BIT];
        transmit_end_flag_d = transmit_end_flag_q;
        if (!ctrl_q.transmit_enable || (tx_evt.last_bit && fl_q[`SSF_TX_EMPTY_BIT])) begin
            transmit_end_flag_d = 1'b1; // see RULE6 see RULE21
        end else if (transmit_empty_flag_sw_clr || tx_evt.ctl_write) begin
            transmit_end_flag_d = 1'b0; // see RULE7
        end
        rx_mpb_d = rx_mpb_q;
        if (rx_live && !ctrl_q.card_mode_select) begin
            rx_mpb_d = rx_evt.rx_multiproc_bit; // see RULE8 see RULE9
        end
        tx_mpb_d = tx_mpb_q;
        if (wr_status) begin
            tx_mpb_d = pwdata[`SSF_TX_MPB_BIT]; // see RULE10
        end
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.transmit_enable = pwdata[`SSF_CTRL_TE_BIT];
            ctrl_d.receive_enable = pwdata[`SSF_CTRL_RE_BIT];
            ctrl_d.card_mode_select = pwdata[`SSF_CTRL_CARD_BIT];
        end
        treq_d = ctrl_q.transmit_enable && fl_q[`SSF_TX_EMPTY_BIT];
        rreq_d = fl_q[`SSF_RX_FULL_BIT];
        acc_d = rx_clean;
        status_now = {fl_q, transmit_end_flag_q, rx_mpb_q, tx_mpb_q};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SSF_CTRL_RST;
            transmit_end_flag_q <= 1'(`SSF_STATUS_RST >> `SSF_TX_END_BIT);
            rx_mpb_q <= 1'b0;
            tx_mpb_q <= 1'b0;
            treq_q <= 1'b0;
            rreq_q <= 1'b0;
            acc_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            transmit_end_flag_q <= transmit_end_flag_d;
            rx_mpb_q <= rx_mpb_d;
            tx_mpb_q <= tx_mpb_d;
            treq_q <= treq_d;
            rreq_q <= rreq_d;
            acc_q <= acc_d;
        end
    end

    always_comb begin
        pready = pready_q;
        pslverr = pslverr_q;
        prdata = prdata_q;
        serial_status = status_now;
        serial_control = ctrl_q;
        tx_multiproc_bit = tx_mpb_q;
        transmit_request = treq_q;
        receive_request = rreq_q;
        rx_accept = acc_q;
    end
endmodule : ssf_status

// File: tb/ssf_line_model.sv
// far-side serial line: received characters and the card error signal
// assumes pclk-domain event pulses as the status block expects
`timescale 1ns/1ps
module ssf_line_model
    import ssf_pkg::*;
(
    input wire logic pclk,
    output ssf_rx_evt_s rx_evt,
    output logic card_err_pin
);
    initial begin
        rx_evt = '0;
        card_err_pin = 1'b1;
    end
    // one character after gap cycles; lines change once released
    task automatic frame(input logic stop1, input logic perr, input logic rx_multiproc_bit, input int gap);
        repeat (gap) @(posedge pclk);
        rx_evt <= '{done: 1'b1, stop1: stop1, parity_err: perr, rx_multiproc_bit: rx_multiproc_bit};
        @(posedge pclk);
        rx_evt <= '{done: 1'b0, stop1: ~stop1, parity_err: ~perr, rx_multiproc_bit: ~rx_multiproc_bit};
    endtask : frame
    // error signal held low for len cycles
    task automatic err_sig(input int len);
        card_err_pin <= 1'b0;
        repeat (len) @(posedge pclk);
        card_err_pin <= 1'b1;
    endtask : err_sig
endmodule : ssf_line_model

// File: tb/ssf_status_asserts.sv
// concurrent checks on the serial status block ports
// assumes it is bound into ssf_status
`timescale 1ns/1ps
module ssf_status_asserts
    import ssf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ssf_rx_evt_s rx_evt,
    input wire ssf_tx_evt_s tx_evt,
    input wire ssf_byte_t serial_status,
    input wire ssf_ctrl_s serial_control,
    input wire logic transmit_request,
    input wire logic receive_request,
    input wire logic rx_accept
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rx;
        rx_evt.done && serial_control.receive_enable;
    endsequence
    property p_ovr_set; s_rx ##0 serial_status[6] |=> serial_status[5]; endproperty
    property p_ovr_src; $rose(serial_status[5]) |-> $past(rx_evt.done && serial_status[6]);
    endproperty
    property p_rxf_src; $rose(serial_status[6]) |-> $past(rx_evt.done && !rx_evt.parity_err);
    endproperty
    property p_par_set; s_rx ##0 rx_evt.parity_err |=> serial_status[3]; endproperty
    property p_fer_set;
        s_rx ##0 (!rx_evt.stop1 && !serial_control.card_mode_select) |=> serial_status[4];
    endproperty
    property p_txe_dis;
        !serial_control.transmit_enable |=> serial_status[7] && serial_status[2];
    endproperty
    property p_ctl_wr;
        tx_evt.ctl_write && !tx_evt.load && !tx_evt.last_bit && serial_control.transmit_enable
            |=> !serial_status[7] && !serial_status[2];
    endproperty
    property p_mpb_cap;
        s_rx ##0 !serial_control.card_mode_select |=> serial_status[1] == $past(rx_evt.rx_multiproc_bit);
    endproperty
    property p_mpb_hold; !serial_control.receive_enable |=> $stable(serial_status[1]); endproperty
    sequence s_rx_ok;
        s_rx ##0 (!serial_status[6] && !rx_evt.parity_err
            && (serial_control.card_mode_select || rx_evt.stop1));
    endsequence
    property p_acc_set; s_rx_ok |=> rx_accept && serial_status[6]; endproperty
    property p_acc_src; rx_accept |-> $past(rx_evt.done && serial_control.receive_enable);
    endproperty
    property p_rreq; receive_request == $past(serial_status[6]); endproperty
    property p_treq;
        transmit_request == $past(serial_control.transmit_enable && serial_status[7]);
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");
    a_ovr_src: assert property (p_ovr_src) else $error("overrun rose alone");
    a_rxf_src: assert property (p_rxf_src) else $error("receive full rose alone");
    a_par_set: assert property (p_par_set) else $error("parity flag not set");
    a_fer_set: assert property (p_fer_set) else $error("framing flag not set");
    a_txe_dis: assert property (p_txe_dis) else $error("tx flags low when off");
    a_ctl_wr: assert property (p_ctl_wr) else $error("tx flags kept");
    a_mpb_cap: assert property (p_mpb_cap) else $error("mp bit not captured");
    a_mpb_hold: assert property (p_mpb_hold) else $error("mp bit moved");
    a_acc_set: assert property (p_acc_set) else $error("byte not accepted");
    a_acc_src: assert property (p_acc_src) else $error("accept pulse alone");
    a_rreq: assert property (p_rreq) else $error("receive request wrong");
    a_treq: assert property (p_treq) else $error("transmit request wrong");
endmodule : ssf_status_asserts
bind ssf_status ssf_status_asserts u_chk (.*);

// File: tb/tb_top.sv
// self-checking bench for the serial status block
// assumes an apb master, a line model and bench-driven strobes
`timescale 1ns/1ps
`include "ssf_map.svh"
module tb_top
    import ssf_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [`SSF_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, r;
    logic pready, pslverr, ctl_rx_read = 1'b0, card_err_sample = 1'b0, card_err_pin;
    logic tx_multiproc_bit, transmit_request, receive_request;
    logic [31:0] rs = 32'h2A;
    ssf_rx_evt_s rx_evt;
    ssf_tx_evt_s tx_evt = '0;
    int fails = 0, samples_checked = 0;
    ssf_line_model mdl (.pclk(pclk), .rx_evt(rx_evt), .card_err_pin(card_err_pin));
    ssf_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .rx_evt(rx_evt), .tx_evt(tx_evt), .ctl_rx_read(ctl_rx_read),
        .card_err_sample(card_err_sample), .card_err_pin(card_err_pin), .serial_status(),
        .serial_control(), .tx_multiproc_bit(tx_multiproc_bit),
        .transmit_request(transmit_request), .receive_request(receive_request), .rx_accept());
    initial begin
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd
    function automatic logic [31:0] rx_exp(input logic full, input logic rx_multiproc_bit);
        return {25'h0, full, 4'h0, rx_multiproc_bit, 1'b0};
    endfunction : rx_exp
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse(input logic [4:0] m);
        {tx_evt, ctl_rx_read, card_err_sample} <= m;
        @(posedge pclk);
        {tx_evt, ctl_rx_read, card_err_sample} <= 5'h00;
        @(posedge pclk);
    endtask : pulse
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0); chk(q, 32'h84);
        apb(0, 8'h08, 0); chk({q[30:0], err}, 32'h1);
        apb(1, 8'h04, 3); apb(1, 8'h00, 32'hFF); apb(0, 8'h00, 0); chk(q, 32'h85);
        chk({31'h0, tx_multiproc_bit}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            mdl.frame(1'b1, 1'b0, r[0], 1 + r[3:2]);
            apb(0, 8'h00, 0); chk(q & 32'h42, rx_exp(1'b1, r[0]));
            chk({31'h0, receive_request}, 32'h1);
            pulse(5'h02); apb(0, 8'h00, 0); chk(q & 32'h42, rx_exp(1'b0, r[0]));
            chk({31'h0, receive_request}, 32'h0);
        end
        mdl.frame(1, 0, 0, 1); mdl.frame(1, 0, 0, 3);
        apb(0, 8'h00, 0); chk(q & 32'h60, 32'h60);
        apb(1, 8'h00, 32'hFF); apb(1, 8'h00, 32'h9F);
        apb(0, 8'h00, 0); chk(q & 32'h60, 32'h60);
        apb(1, 8'h00, 32'hDF); apb(0, 8'h00, 0); chk(q & 32'h60, 32'h40);
        apb(1, 8'h00, 32'hBF); apb(0, 8'h00, 0); chk(q & 32'h60, 0);
        mdl.frame(0, 0, 0, 2); mdl.frame(1, 1, 0, 2);
        apb(0, 8'h00, 0); chk(q & 32'h58, 32'h18);
        apb(1, 8'h00, 32'hE7); apb(0, 8'h00, 0); chk(q & 32'h58, 0);
        mdl.frame(1, 0, 1, 1); apb(1, 8'h04, 1); mdl.frame(1, 0, 0, 1); mdl.frame(1, 0, 0, 2);
        apb(0, 8'h00, 0); chk(q & 32'h62, 32'h42);
        pulse(5'h02); apb(1, 8'h04, 3); apb(0, 8'h00, 0);
        apb(1, 8'h00, 32'h7F); apb(0, 8'h00, 0); chk(q & 32'h84, 0);
        pulse(5'h10); pulse(5'h08); apb(0, 8'h00, 0); chk(q & 32'h84, 32'h84);
        pulse(5'h04); apb(0, 8'h00, 0); chk(q & 32'h84, 0);
        chk({31'h0, transmit_request}, 32'h0);
        pulse(5'h10); apb(0, 8'h00, 0); chk(q & 32'h84, 32'h80);
        // load lands on the access edge of the clearing write
        fork
            apb(1, 8'h00, 32'h7F);
            begin
                @(posedge pclk);
                pulse(5'h10);
            end
        join
        apb(0, 8'h00, 0); chk(q & 32'h84, 32'h80);
        chk({31'h0, transmit_request}, 32'h1);
        apb(1, 8'h04, 7); mdl.frame(0, 0, 0, 1);
        apb(0, 8'h00, 0); chk(q & 32'h10, 0);
        fork
            mdl.err_sig(6);
            begin
                repeat (4) @(posedge pclk);
                pulse(5'h01);
            end
        join
        apb(0, 8'h00, 0); chk(q & 32'h10, 32'h10);
        apb(1, 8'h00, 32'hEF); apb(0, 8'h00, 0); chk(q & 32'h10, 0);
        print_verdict();
    end
endmodule : tb_top
